// ---- src/isrs_cfg.svh ----
/*
 constants of the serial ram target: addresses, flag and command bit positions, reset values.
 assumes inclusion by isrs_top.sv only, after the package.
*/
`ifndef ISRS_CFG_SVH
`define ISRS_CFG_SVH
`define ISRS_OWN_ADDR 8'ha0
`define ISRS_REG_CMD 8'h00
`define ISRS_RAM_FIRST 8'h80
`define ISRS_RAM_LAST 8'hff
`define ISRS_INIT_LAST 7'h7f
`define ISRS_RX_LEN 5'h10
`define ISRS_RXN_MAX 5'h11
`define ISRS_FIFO_DEPTH 8
`define ISRS_FLAGS_RST 8'h00
`define ISRS_CMD_RST 8'h00
`define ISRS_F_NOTSEL 7
`define ISRS_F_ZERO 6
`define ISRS_F_PTR 5
`define ISRS_F_OVER 4
`define ISRS_F_FULL 3
`define ISRS_F_SEND 2
`define ISRS_F_NACK 1
`define ISRS_F_STOP 0
`define ISRS_C_VALID 7
`define ISRS_C_WPROT 2
`define ISRS_C_INIT 1
`define ISRS_C_PAT 0
`endif

// ---- src/isrs_pkg.sv ----
/*
 types of the serial ram target: fsm states, byte roles, write word, state record.
 assumes nothing of its surroundings.
*/
package isrs_pkg;
   typedef enum logic [6:0] {
      S_IDLE = 7'h01,
      S_RX = 7'h02,
      S_DEC = 7'h04,
      S_ACK = 7'h08,
      S_LD = 7'h10,
      S_TX = 7'h20,
      S_MACK = 7'h40
   } isrs_st_e;
   typedef enum logic [2:0] {
      R_ADDR = 3'h0,
      R_REG = 3'h1,
      R_CMD = 3'h2,
      R_DATA = 3'h3,
      R_END = 3'h4
   } isrs_role_e;
   typedef struct packed {
      logic [6:0] idx;
      logic [7:0] data;
   } isrs_wr_s;
   typedef struct packed {
      logic [2:0] scl_sync;
      logic [2:0] sda_sync;
      logic scl_f;
      logic sda_f;
   } isrs_pin_s;
   typedef struct packed {
      isrs_pin_s pin;
      isrs_st_e st;
      isrs_role_e role;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic rw;
      logic sel;
      logic ack_seen;
      logic evt;
      logic [7:0] ptr;
      logic [4:0] rxn;
      logic [7:0] flags;
      logic [7:0] cmd;
      logic init_busy;
      logic [6:0] init_idx;
      logic [127:0][7:0] ram;
   } isrs_state_s;
endpackage : isrs_pkg

// ---- src/isrs_top.sv ----
/*
 i2c target emulating a 128 byte serial ram with a command register, plus its write fifo.
 assumes open-drain pins resolved outside, one bus master, core_clk far faster than scl.
*/
`timescale 1ns/1ps
`include "isrs_cfg.svh"

module isrs_fifo #(
   parameter int W = 15,
   parameter int D = 8
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(D);
   localparam logic [AW:0] FULL = (AW+1)'(D);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } isrs_fifo_s;
   isrs_fifo_s f_ff;
   isrs_fifo_s nxt_f;
   logic push;
   logic pop;

   assign in_ready = (f_ff.cnt != FULL);
   assign out_valid = (f_ff.cnt != '0);
   assign out_data = f_ff.mem[f_ff.rp];

   always_comb begin
      nxt_f = f_ff;
      push = in_valid & in_ready;
      pop = out_valid & out_ready;
      if (push) begin
         nxt_f.mem[f_ff.wp] = in_data;
         nxt_f.wp = f_ff.wp + 1'b1;
      end
      if (pop) begin
         nxt_f.rp = f_ff.rp + 1'b1;
      end
      if (push & ~pop) begin
         nxt_f.cnt = f_ff.cnt + 1'b1;
      end else if (pop & ~push) begin
         nxt_f.cnt = f_ff.cnt - 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         f_ff <= '0;
      end else begin
         f_ff <= nxt_f;
      end
   end
endmodule : isrs_fifo

// Functional notes
// - answer only target address 0b1010000, held left aligned as 0xA0.
// - transfer event fires on the ninth, acknowledge clock of each byte the block acknowledges or sends.
// - stop raises no event, only the stop flag.
// - clock and data inputs pass a digital noise filter.
// - extension code instead of own address drops the transaction.
// - register address 0x01 to 0x7F is refused and the block withdraws.
// - register 0x00 is acknowledged, next byte is a command, ack or nack.
// - register address 0x80 to 0xFF is latched as ram pointer.
// - reads send successive bytes from the pointer until master nacks.
// - writes store successive bytes from the pointer.
// - stop ends participation in the transaction.
// - start restarts address matching.
// - scl held low on data bytes during ram init or other pending work.
// - receive path buffers data within one transaction.
// - flag bit 7 set on foreign address after restart, cleared on own.
// - flag bit 5 set on every register address latch; bit 6 reads zero.
// - flag bit 3 at expected byte count, bit 4 when exceeded.
// - flag bit 2 set on read request from master.
// - flag bit 1 on master nack after sent byte, bit 0 on stop.
// - pointer advances per byte and wraps 0xFF to 0x80.
// - command acted on only when its bit 7 is one.
// - command bit 2 refuses write data bytes and withdraws.
// - command bit 1 fills ram with zero or low address bits, then clears.
module isrs_top
   import isrs_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic serial_clock_pin_in,
   output logic serial_clock_pin_out,
   output logic serial_clock_pin_oe,
   input wire logic serial_data_pin_in,
   output logic serial_data_pin_out,
   output logic serial_data_pin_oe,
   output logic transfer_event_interrupt,
   output logic [7:0] slave_state_flags,
   output logic [7:0] command_state,
   output logic init_busy
);
   isrs_state_s st_ff;
   isrs_state_s nxt_st;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic count_byte;
   logic stall_rx;
   logic stall_tx;
   logic wr_valid;
   logic wr_ready;
   isrs_wr_s wr_data;
   logic rd_valid;
   isrs_wr_s rd_data;

   function automatic logic [7:0] ptr_inc(input logic [7:0] p);
      ptr_inc = (p == `ISRS_RAM_LAST) ? `ISRS_RAM_FIRST : p + 8'h01;
   endfunction : ptr_inc

   // ram writes queue here so a slow init does not lose bytes; full stretches scl
   isrs_fifo #(
      .W($bits(isrs_wr_s)),
      .D(`ISRS_FIFO_DEPTH)
   ) u_wr_fifo (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .in_valid(wr_valid),
      .in_ready(wr_ready),
      .in_data(wr_data),
      .out_valid(rd_valid),
      .out_ready(~st_ff.init_busy),
      .out_data(rd_data)
   );

   // open drain: only ever pull low
   assign serial_clock_pin_out = 1'b0;
   assign serial_data_pin_out = 1'b0;
   assign serial_clock_pin_oe = (st_ff.st == S_DEC) | (st_ff.st == S_LD);
   assign serial_data_pin_oe = (st_ff.st == S_ACK) | ((st_ff.st == S_TX) & ~st_ff.sh[7]);
   assign transfer_event_interrupt = st_ff.evt;
   assign slave_state_flags = st_ff.flags;
   assign command_state = st_ff.cmd;
   assign init_busy = st_ff.init_busy;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.evt = 1'b0;
      wr_valid = 1'b0;
      wr_data = '0;
      count_byte = 1'b0;
      // three stage sync; filtered level moves only when stages two and three agree
      nxt_st.pin.scl_sync = {st_ff.pin.scl_sync[1:0], serial_clock_pin_in};
      nxt_st.pin.sda_sync = {st_ff.pin.sda_sync[1:0], serial_data_pin_in};
      if (st_ff.pin.scl_sync[2] == st_ff.pin.scl_sync[1]) begin
         nxt_st.pin.scl_f = st_ff.pin.scl_sync[2];
      end
      if (st_ff.pin.sda_sync[2] == st_ff.pin.sda_sync[1]) begin
         nxt_st.pin.sda_f = st_ff.pin.sda_sync[2];
      end
      scl_rise = nxt_st.pin.scl_f & ~st_ff.pin.scl_f;
      scl_fall = ~nxt_st.pin.scl_f & st_ff.pin.scl_f;
      start_seen = st_ff.pin.scl_f & nxt_st.pin.scl_f & st_ff.pin.sda_f & ~nxt_st.pin.sda_f;
      stop_seen = st_ff.pin.scl_f & nxt_st.pin.scl_f & ~st_ff.pin.sda_f & nxt_st.pin.sda_f;
      stall_rx = st_ff.init_busy | ~wr_ready;
      // reads wait until queued writes have landed
      stall_tx = st_ff.init_busy | rd_valid;
      // ram fill has priority over queued writes
      if (st_ff.init_busy) begin
         nxt_st.ram[st_ff.init_idx] = st_ff.cmd[`ISRS_C_PAT] ? {1'b0, st_ff.init_idx} : 8'h00;
         nxt_st.init_idx = st_ff.init_idx + 7'h01;
         if (st_ff.init_idx == `ISRS_INIT_LAST) begin
            nxt_st.init_busy = 1'b0;
            nxt_st.cmd[`ISRS_C_INIT] = 1'b0;
         end
      end else if (rd_valid) begin
         nxt_st.ram[rd_data.idx] = rd_data.data;
      end
      if (stop_seen) begin
         nxt_st.st = S_IDLE;
         nxt_st.sel = 1'b0;
         nxt_st.flags[`ISRS_F_STOP] = 1'b1; // no event on stop
      end else if (start_seen) begin
         nxt_st.st = S_RX;
         nxt_st.role = R_ADDR;
         nxt_st.cnt = 4'h0;
      end else begin
         unique case (st_ff.st)
            S_IDLE: begin
            end
            S_RX: begin
               if (scl_rise) begin
                  nxt_st.sh = {st_ff.sh[6:0], st_ff.pin.sda_f};
                  nxt_st.cnt = st_ff.cnt + 4'h1;
               end else if (scl_fall && st_ff.cnt == 4'h8) begin
                  nxt_st.st = S_DEC;
               end
            end
            S_DEC: begin
               nxt_st.st = S_ACK;
               unique case (st_ff.role)
                  R_ADDR: begin
                     if (st_ff.sh[7:1] == 7'(`ISRS_OWN_ADDR >> 1)) begin
                        if (!st_ff.sel) begin
                           nxt_st.flags = `ISRS_FLAGS_RST;
                           nxt_st.rxn = 5'h00;
                        end
                        nxt_st.flags[`ISRS_F_NOTSEL] = 1'b0;
                        nxt_st.rw = st_ff.sh[0];
                        nxt_st.flags[`ISRS_F_SEND] = st_ff.sh[0];
                        nxt_st.sel = 1'b1;
                        nxt_st.role = st_ff.sh[0] ? R_DATA : R_REG;
                     end else begin
                        // extension codes land here too: no ack, wait for next start
                        nxt_st.st = S_IDLE;
                        if (st_ff.sel) begin
                           nxt_st.flags[`ISRS_F_NOTSEL] = 1'b1;
                        end
                     end
                  end
                  R_REG: begin
                     if (st_ff.sh == `ISRS_REG_CMD) begin
                        nxt_st.role = R_CMD;
                        nxt_st.flags[`ISRS_F_PTR] = 1'b1;
                        count_byte = 1'b1;
                     end else if (st_ff.sh >= `ISRS_RAM_FIRST) begin
                        nxt_st.ptr = st_ff.sh;
                        nxt_st.role = R_DATA;
                        nxt_st.flags[`ISRS_F_PTR] = 1'b1;
                        count_byte = 1'b1;
                     end else begin
                        nxt_st.st = S_IDLE;
                     end
                  end
                  R_CMD: begin
                     if (st_ff.sh[`ISRS_C_VALID]) begin
                        nxt_st.cmd = st_ff.sh;
                        nxt_st.role = R_END;
                        count_byte = 1'b1;
                        if (st_ff.sh[`ISRS_C_INIT]) begin
                           nxt_st.init_busy = 1'b1;
                           nxt_st.init_idx = 7'h00;
                        end
                     end else begin
                        nxt_st.st = S_IDLE;
                     end
                  end
                  R_DATA: begin
                     if (st_ff.cmd[`ISRS_C_WPROT]) begin
                        nxt_st.st = S_IDLE;
                     end else if (stall_rx) begin
                        nxt_st.st = S_DEC;
                     end else begin
                        wr_valid = 1'b1;
                        wr_data.idx = st_ff.ptr[6:0];
                        wr_data.data = st_ff.sh;
                        nxt_st.ptr = ptr_inc(st_ff.ptr);
                        count_byte = 1'b1;
                     end
                  end
                  default: begin
                     nxt_st.st = S_IDLE;
                  end
               endcase
            end
            S_ACK: begin
               if (scl_rise) begin
                  nxt_st.evt = 1'b1;
               end else if (scl_fall) begin
                  nxt_st.st = st_ff.rw ? S_LD : S_RX;
                  nxt_st.cnt = 4'h0;
               end
            end
            S_LD: begin
               if (!stall_tx) begin
                  nxt_st.sh = st_ff.ram[st_ff.ptr[6:0]];
                  nxt_st.ptr = ptr_inc(st_ff.ptr);
                  nxt_st.cnt = 4'h0;
                  nxt_st.st = S_TX;
               end
            end
            S_TX: begin
               if (scl_fall) begin
                  if (st_ff.cnt == 4'h7) begin
                     nxt_st.st = S_MACK;
                     nxt_st.ack_seen = 1'b0;
                  end else begin
                     nxt_st.sh = {st_ff.sh[6:0], 1'b0};
                     nxt_st.cnt = st_ff.cnt + 4'h1;
                  end
               end
            end
            S_MACK: begin
               if (scl_rise) begin
                  nxt_st.evt = 1'b1;
                  if (st_ff.pin.sda_f) begin
                     nxt_st.flags[`ISRS_F_NACK] = 1'b1;
                     nxt_st.st = S_IDLE;
                  end else begin
                     nxt_st.ack_seen = 1'b1;
                  end
               end else if (scl_fall && st_ff.ack_seen) begin
                  nxt_st.st = S_LD;
               end
            end
            default: begin
               nxt_st.st = S_IDLE;
            end
         endcase
      end
      // byte count includes the register address byte; saturates one past the limit
      if (count_byte) begin
         nxt_st.rxn = (st_ff.rxn == `ISRS_RXN_MAX) ? st_ff.rxn : st_ff.rxn + 5'h01;
         if (nxt_st.rxn == `ISRS_RX_LEN) begin
            nxt_st.flags[`ISRS_F_FULL] = 1'b1;
         end
         if (nxt_st.rxn == `ISRS_RXN_MAX) begin
            nxt_st.flags[`ISRS_F_OVER] = 1'b1;
         end
      end
      nxt_st.flags[`ISRS_F_ZERO] = 1'b0;
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_ff <= '0;
         st_ff.st <= S_IDLE;
         st_ff.pin <= '{scl_sync: 3'h7, sda_sync: 3'h7, scl_f: 1'b1, sda_f: 1'b1};
         st_ff.flags <= `ISRS_FLAGS_RST;
         st_ff.cmd <= `ISRS_CMD_RST;
         st_ff.ptr <= `ISRS_RAM_FIRST;
      end else begin
         st_ff <= nxt_st;
      end
   end
endmodule : isrs_top

// ---- verif/isrs_chk.sv ----
/*
 port checker for the serial ram target, bound to isrs_top.
 assumes one clock domain and the wires resolved outside the top.
*/
`timescale 1ns/1ps
module isrs_chk (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic serial_clock_pin_in,
   input wire logic serial_clock_pin_oe,
   input wire logic serial_data_pin_in,
   input wire logic transfer_event_interrupt,
   input wire logic [7:0] slave_state_flags,
   input wire logic [7:0] command_state,
   input wire logic init_busy
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);
   property p_flag_zero;
      slave_state_flags[6] == 1'b0;
   endproperty
   a_flag_zero: assert property (p_flag_zero) else $error("flag bit 6 set");
   property p_evt_ack_clk;
      transfer_event_interrupt |-> serial_clock_pin_in;
   endproperty
   a_evt_ack_clk: assert property (p_evt_ack_clk) else $error("event outside high clock");
   property p_stop_quiet;
      serial_clock_pin_in && $rose(serial_data_pin_in) |=> !transfer_event_interrupt [*8];
   endproperty
   a_stop_quiet: assert property (p_stop_quiet) else $error("event after stop");
   property p_stretch;
      serial_clock_pin_oe && init_busy |=> serial_clock_pin_oe;
   endproperty
   a_stretch: assert property (p_stretch) else $error("clock released during fill");
   property p_fill_len;
      $rose(init_busy) |-> ##126 init_busy ##[1:4] !init_busy;
   endproperty
   a_fill_len: assert property (p_fill_len) else $error("fill length wrong");
   property p_cmd_valid;
      command_state != 8'h00 |-> command_state[7];
   endproperty
   a_cmd_valid: assert property (p_cmd_valid) else $error("invalid command stored");
   property p_stop_flag;
      $rose(slave_state_flags[0]) |-> serial_clock_pin_in && serial_data_pin_in;
   endproperty
   a_stop_flag: assert property (p_stop_flag) else $error("stop flag without stop");
   property p_over;
      $rose(slave_state_flags[4]) |-> slave_state_flags[3];
   endproperty
   a_over: assert property (p_over) else $error("overflow before full");
endmodule : isrs_chk
bind isrs_top isrs_chk isrs_chk_inst (.core_clk(core_clk), .rst_b(rst_b), .serial_clock_pin_in(serial_clock_pin_in),
   .serial_clock_pin_oe(serial_clock_pin_oe), .serial_data_pin_in(serial_data_pin_in),
   .transfer_event_interrupt(transfer_event_interrupt), .slave_state_flags(slave_state_flags),
   .command_state(command_state), .init_busy(init_busy));

// ---- verif/isrs_master.sv ----
/*
 behavioural single bus master for the serial ram target.
 assumes pull-ups on both wires, resolved by the bench.
*/
`timescale 1ns/1ps
module isrs_master (
   input wire logic core_clk,
   input wire logic scl,
   input wire logic sda,
   output logic scl_oe,
   output logic sda_oe
);
   initial begin
      scl_oe = 1'b0;
      sda_oe = 1'b0;
   end
   // half of a 160 ns bus period
   task automatic hp();
      repeat (10) @(negedge core_clk);
   endtask : hp
   // bounded wait so a stuck stretch cannot hang the model
   task automatic rise();
      int n;
      n = 0;
      scl_oe = 1'b0;
      @(negedge core_clk);
      while (!scl && n < 400) begin
         @(negedge core_clk);
         n++;
      end
      // ten cycles high counting the release edge
      repeat (9) @(negedge core_clk);
   endtask : rise
   task automatic start();
      sda_oe = 1'b0;
      hp();
      rise();
      sda_oe = 1'b1;
      hp();
      scl_oe = 1'b1;
   endtask : start
   // data moves a few cycles after the fall so the filters see clock first
   task automatic bit_io(input logic b, output logic r);
      repeat (3) @(negedge core_clk);
      sda_oe = !b;
      // ten cycles low in all, so one bit is 160 ns
      repeat (7) @(negedge core_clk);
      rise();
      r = sda;
      scl_oe = 1'b1;
   endtask : bit_io
   task automatic stop();
      repeat (3) @(negedge core_clk);
      sda_oe = 1'b1;
      repeat (7) @(negedge core_clk);
      rise();
      sda_oe = 1'b0;
      hp();
   endtask : stop
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = !r;
   endtask : wbyte
   task automatic rbyte(input logic mack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(!mack, r);
   endtask : rbyte
endmodule : isrs_master

// ---- verif/tb_top.sv ----
/*
 self-checking bench for the serial ram target with a bus master model.
 assumes the checker is bound by its own file.
*/
`timescale 1ns/1ps
module tb_top;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic m_scl_oe, m_sda_oe, s_scl_oe, s_sda_oe, evt, busy, ack;
   logic [7:0] flags, cmd, d;
   logic [7:0] mem [0:127];
   int mismatches = 0;
   int checked = 0;
   int evts = 0;
   int cyc = 0;
   wire scl = !(m_scl_oe | s_scl_oe);
   wire sda = !(m_sda_oe | s_sda_oe);
   isrs_top isrs_top_inst (.core_clk(core_clk), .rst_b(rst_b), .serial_clock_pin_in(scl), .serial_clock_pin_out(),
      .serial_clock_pin_oe(s_scl_oe), .serial_data_pin_in(sda), .serial_data_pin_out(), .serial_data_pin_oe(s_sda_oe),
      .transfer_event_interrupt(evt), .slave_state_flags(flags), .command_state(cmd), .init_busy(busy));
   isrs_master isrs_master_inst (.core_clk(core_clk), .scl(scl), .sda(sda), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));
   initial forever #4 core_clk = ~core_clk;
   task automatic tally_and_finish();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : tally_and_finish
   always @(posedge core_clk) begin
      cyc++;
      if (evt === 1'b1) evts++;
      if (cyc == 60000) begin
         mismatches++;
         tally_and_finish();
      end
   end
   task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp
   task automatic cmpb(input string what, input logic exp, input logic got);
      cmp(what, {7'h00, exp}, {7'h00, got});
   endtask : cmpb
   function automatic logic [7:0] ptr_next(input logic [7:0] p);
      return (p == 8'hff) ? 8'h80 : p + 8'h01;
   endfunction : ptr_next
   task automatic sb(input logic [7:0] b, input logic e);
      isrs_master_inst.wbyte(b, ack);
      cmpb("ack", e, ack);
   endtask : sb
   // one frame; bit i of em is the acknowledge expected for byte i
   task automatic go(input logic [7:0] bs [$], input logic [31:0] em);
      isrs_master_inst.start();
      foreach (bs[i]) sb(bs[i], em[i]);
      isrs_master_inst.stop();
   endtask : go
   task automatic wr(input logic [7:0] r, input int n);
      logic [7:0] p, v;
      p = r;
      go({8'ha0, r}, 32'h3);
      isrs_master_inst.start();
      sb(8'ha0, 1'b1);
      sb(r, 1'b1);
      repeat (n) begin
         v = 8'($urandom);
         sb(v, 1'b1);
         mem[p[6:0]] = v;
         p = ptr_next(p);
      end
      isrs_master_inst.stop();
   endtask : wr
   task automatic rd(input logic [7:0] r, input int n);
      logic [7:0] p;
      p = r;
      isrs_master_inst.start();
      sb(8'ha0, 1'b1);
      sb(r, 1'b1);
      isrs_master_inst.start();
      sb(8'ha1, 1'b1);
      for (int i = 0; i < n; i++) begin
         isrs_master_inst.rbyte(i < n - 1, d);
         cmp("read byte", mem[p[6:0]], d);
         p = ptr_next(p);
      end
      isrs_master_inst.stop();
   endtask : rd
   initial begin
      void'($urandom(47));
      foreach (mem[i]) mem[i] = 8'h00;
      repeat (2) @(posedge core_clk);
      @(negedge core_clk) rst_b = 1'b1;
      repeat (4) @(negedge core_clk);
      cmp("flags", 8'h00, flags);
      cmp("command", 8'h00, cmd);
      cmpb("busy", 1'b0, busy);
      go({8'ha2}, 32'h0);
      go({8'hf0}, 32'h0);
      go({8'ha0, 8'h10}, 32'h1);
      go({8'ha0, 8'h7f}, 32'h1);
      wr(8'hfe, 4);
      evts = 0;
      // pointer frame acks two bytes, data frame six; the two stops add none
      wr(8'hfe, 4);
      cmp("events", 8'd8, 8'(evts));
      cmp("flags", 8'h21, flags);
      rd(8'hfe, 4);
      cmp("flags", 8'h27, flags);
      wr(8'h90, 16);
      cmp("flags", 8'h39, flags);
      rd(8'h90, 16);
      go({8'ha0, 8'h00, 8'h02}, 32'h3);
      cmp("command", 8'h00, cmd);
      go({8'ha0, 8'h00, 8'h84}, 32'h7);
      cmp("command", 8'h84, cmd);
      go({8'ha0, 8'h90, 8'h55}, 32'h3);
      go({8'ha0, 8'h00, 8'h83}, 32'h7);
      foreach (mem[i]) mem[i] = 8'(i);
      rd(8'hfe, 3);
      cmp("command", 8'h81, cmd);
      isrs_master_inst.start();
      sb(8'ha0, 1'b1);
      sb(8'h80, 1'b1);
      isrs_master_inst.start();
      sb(8'ha2, 1'b0);
      isrs_master_inst.stop();
      cmp("flags", 8'ha1, flags);
      tally_and_finish();
   end
endmodule : tb_top
